// *** core/hub_regs_consts.svh ***
/*
 Offsets, field positions, reset values and code points of the hub string and
 charger register group. Assumes inclusion by bare name from core/.
*/
`ifndef HUB_REGS_CONSTS_SVH
`define HUB_REGS_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PRODUCT_TEXT_LO 8'h54
`define PRODUCT_TEXT_HI 8'h91
`define SERIAL_TEXT_LO 8'h92
`define SERIAL_TEXT_HI 8'hCF
`define CHARGE_ENABLE_OFF 8'hD0
`define CHARGER_DETECT_OFF 8'hE2
`define TEXT_BYTES 62

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CHG_EN_HI 3
`define CHG_EN_LO 1
`define CLASS_HI 7
`define CLASS_LO 5
`define DONE_BIT 4
`define FOUND_LOW_BIT 1
`define GO_BIT 0

// ---------------------------------------------------------------
// reset values and result codes
// ---------------------------------------------------------------
`define TEXT_RESET 8'h00
`define CHARGE_ENABLE_RESET 3'h0
`define FOUND_LOW_RESET 1'b1
`define CODE_INCOMPLETE 3'h0
`define CODE_DCP 3'h1
`define CODE_CDP 3'h2
`define CODE_SDP 3'h3
`define CODE_DISABLED 3'h7
`define UNMAPPED_READ 8'h00

`endif

// *** core/hub_regs_pkg.sv ***
/*
 Types of the hub string and charger register group: bus request, detector
 report, detection state and the module state record.
 Assumes hub_regs_consts.svh is on the include path.
*/
package hub_regs_pkg;
`include "hub_regs_consts.svh"

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [2:0] {
      CLS_NONE = 3'h0,
      CLS_DCP = 3'h1,
      CLS_CDP = 3'h2,
      CLS_SDP = 3'h3,
      CLS_OFF = 3'h4
   } port_class_t;

   typedef struct packed {
      logic done;
      port_class_t cls;
   } detect_report_t;

   // gray along idle -> run -> idle
   typedef enum logic [1:0] {
      DET_IDLE = 2'b00,
      DET_RUN = 2'b01
   } detect_state_t;

   typedef struct packed {
      logic [`TEXT_BYTES-1:0][7:0] productText;
      logic [`TEXT_BYTES-1:0][7:0] serialText;
      logic [`CHG_EN_HI:`CHG_EN_LO] chargeEn;
      detect_state_t det;
      logic [2:0] detectedClass;
      logic doneFlag;
      logic foundLow;
      logic detectGo;
      logic [7:0] rdata;
      logic rvalid;
   } regs_t;
endpackage

// *** core/hub_string_and_charger_regs.sv ***
/*
 Product and serial text areas, downstream charge enables and upstream charger
 detection control/result register of a hub, behind the serial configuration
 port's byte register access. Assumes one clock, inputs synchronous to it, and
 an external detection engine that pulses its report when a run ends.
*/
// Behaviour
// - Offsets 0x54-0x91 hold 62 writable product text bytes, reset to zero.
// - Offsets 0x92-0xCF hold 62 writable serial text bytes, reset to zero.
// - Bits 3:1 at 0xD0 enable charging on downstream ports 3..1; bits 0 and 7:4 reserved.
// - An enable bit at zero disables that port's charging support, at one enables it.
// - With the extended option set, bits 7:5 report 000, 001 DCP, 010 CDP, 011 SDP, 111 off.
// - With the option clear, DCP and CDP both report 001 and 010 is never used.
// - The active-low flag in bit 1 reads zero after a run found an unmasked charger, else one.
// - Writing one to the active-low flag forces it high; writing zero does nothing.
// - Writing one to bit 0 starts a manual run, reads one while it runs, clears when it ends.
`timescale 1ns/1ps
`include "hub_regs_consts.svh"

module hub_string_and_charger_regs
   import hub_regs_pkg::*;
(
   input wire logic clk, // core clock, 100 MHz
   input wire logic rst, // synchronous, active high
   input wire reg_req_t regReq, // byte register access from serial port
   output logic [7:0] regRdata, // read data, one cycle after rd
   output logic regRvalid, // read data valid pulse
   input wire detect_report_t detectReport, // end of a detection run
   input wire logic extendedDetectOption, // enhanced result coding
   input wire logic [2:0] detectTypeFilter, // masks DCP, CDP, SDP (bits 0..2)
   output logic detectGo, // one-cycle manual start pulse
   output logic [`CHG_EN_HI:`CHG_EN_LO] portChargeEnable // per-port charge enable
);

   // every assertion here runs on the core clock and sleeps through reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic inArea(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] hi);
      inArea = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [5:0] idxOf(input logic [7:0] a, input logic [7:0] lo);
      logic [7:0] d;
      d = a - lo;
      idxOf = d[5:0];
   endfunction

   // result coding; reserved codes cannot come out of here
   function automatic logic [2:0] codeOf(input port_class_t c, input logic ext);
      case (c)
         CLS_DCP: codeOf = `CODE_DCP;
         CLS_CDP: codeOf = ext ? `CODE_CDP : `CODE_DCP;
         CLS_SDP: codeOf = `CODE_SDP;
         CLS_OFF: codeOf = `CODE_DISABLED;
         default: codeOf = `CODE_INCOMPLETE;
      endcase
   endfunction

   function automatic logic unmasked(input port_class_t c, input logic [2:0] m);
      case (c)
         CLS_DCP: unmasked = !m[0];
         CLS_CDP: unmasked = !m[1];
         CLS_SDP: unmasked = !m[2];
         default: unmasked = 1'b0;
      endcase
   endfunction

   regs_t state_r;
   regs_t state_nxt;
   logic prodHit;
   logic serHit;
   logic enHit;
   logic detHit;
   logic startReq;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   assign prodHit = inArea(regReq.addr, `PRODUCT_TEXT_LO, `PRODUCT_TEXT_HI);
   assign serHit = inArea(regReq.addr, `SERIAL_TEXT_LO, `SERIAL_TEXT_HI);
   assign enHit = regReq.addr == `CHARGE_ENABLE_OFF;
   assign detHit = regReq.addr == `CHARGER_DETECT_OFF;
   // a start while a run is already going is ignored, it would restart the engine
   assign startReq = regReq.wr && detHit && regReq.wdata[`GO_BIT] && state_r.det == DET_IDLE;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      state_nxt.detectGo = 1'b0;
      state_nxt.rvalid = regReq.rd;
      if (regReq.wr && prodHit) begin
         state_nxt.productText[idxOf(regReq.addr, `PRODUCT_TEXT_LO)] = regReq.wdata;
      end
      if (regReq.wr && serHit) begin
         state_nxt.serialText[idxOf(regReq.addr, `SERIAL_TEXT_LO)] = regReq.wdata;
      end
      if (regReq.wr && enHit) begin
         state_nxt.chargeEn = regReq.wdata[`CHG_EN_HI:`CHG_EN_LO];
      end
      // writing one pushes the flag high, zero is ignored
      if (regReq.wr && detHit && regReq.wdata[`FOUND_LOW_BIT]) begin
         state_nxt.foundLow = 1'b1;
      end
      if (startReq) begin
         state_nxt.doneFlag = 1'b0;
         state_nxt.detectGo = 1'b1;
      end
      case (state_r.det)
         DET_IDLE: begin
            if (startReq) begin
               state_nxt.det = DET_RUN;
            end
         end
         DET_RUN: begin
            if (detectReport.done) begin
               state_nxt.det = DET_IDLE;
            end
         end
         default: state_nxt.det = DET_IDLE;
      endcase
      // a report beats a same-cycle clear from software
      if (detectReport.done) begin
         state_nxt.doneFlag = 1'b1;
         state_nxt.detectedClass = codeOf(detectReport.cls, extendedDetectOption);
         state_nxt.foundLow = !unmasked(detectReport.cls, detectTypeFilter);
      end
      // read data; reserved and unmapped bits come back as zero
      state_nxt.rdata = `UNMAPPED_READ;
      if (regReq.rd) begin
         if (prodHit) begin
            state_nxt.rdata = state_r.productText[idxOf(regReq.addr, `PRODUCT_TEXT_LO)];
         end else if (serHit) begin
            state_nxt.rdata = state_r.serialText[idxOf(regReq.addr, `SERIAL_TEXT_LO)];
         end else if (enHit) begin
            state_nxt.rdata[`CHG_EN_HI:`CHG_EN_LO] = state_r.chargeEn;
         end else if (detHit) begin
            state_nxt.rdata[`CLASS_HI:`CLASS_LO] = state_r.detectedClass;
            state_nxt.rdata[`DONE_BIT] = state_r.doneFlag;
            state_nxt.rdata[`FOUND_LOW_BIT] = state_r.foundLow;
            state_nxt.rdata[`GO_BIT] = state_r.det == DET_RUN;
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= '0;
         state_r.chargeEn <= `CHARGE_ENABLE_RESET;
         state_r.det <= DET_IDLE;
         state_r.detectedClass <= `CODE_INCOMPLETE;
         state_r.foundLow <= `FOUND_LOW_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // outputs straight from flops
   assign regRdata = state_r.rdata;
   assign regRvalid = state_r.rvalid;
   assign detectGo = state_r.detectGo;
   assign portChargeEnable = state_r.chargeEn;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_prod_store;
      regReq.wr && prodHit |=>
         state_r.productText[idxOf($past(regReq.addr), `PRODUCT_TEXT_LO)] == $past(regReq.wdata);
   endproperty
   a_prod_store: assert property (p_prod_store) else $error("product byte not stored");

   property p_ser_readback;
      regReq.wr && serHit ##1 regReq.rd && serHit && regReq.addr == $past(regReq.addr) |=>
         regRvalid && regRdata == $past(regReq.wdata, 2);
   endproperty
   a_ser_readback: assert property (p_ser_readback) else $error("serial byte readback wrong");

   property p_enable_out;
      regReq.wr && enHit |=> portChargeEnable == $past(regReq.wdata[`CHG_EN_HI:`CHG_EN_LO]);
   endproperty
   a_enable_out: assert property (p_enable_out) else $error("charge enable not applied");

   property p_enable_hold;
      !(regReq.wr && enHit) |=> $stable(portChargeEnable);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("charge enable moved");

   property p_ext_cdp;
      detectReport.done && detectReport.cls == CLS_CDP && extendedDetectOption |=>
         state_r.detectedClass == `CODE_CDP;
   endproperty
   a_ext_cdp: assert property (p_ext_cdp) else $error("extended CDP code wrong");

   property p_basic_cdp;
      detectReport.done && detectReport.cls == CLS_CDP && !extendedDetectOption |=>
         state_r.detectedClass == `CODE_DCP;
   endproperty
   a_basic_cdp: assert property (p_basic_cdp) else $error("basic CDP code wrong");

   property p_no_reserved;
      !(state_r.detectedClass inside {3'h4, 3'h5, 3'h6});
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved result code");

   property p_done_flag;
      startReq && !detectReport.done ##1 !detectReport.done |=> !state_r.doneFlag ##0
         state_r.det == DET_RUN;
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("done flag not cleared");

   property p_found;
      detectReport.done |=> state_r.doneFlag &&
         state_r.foundLow == !unmasked($past(detectReport.cls), $past(detectTypeFilter));
   endproperty
   a_found: assert property (p_found) else $error("found flag wrong after run");

   property p_force_high;
      regReq.wr && detHit && regReq.wdata[`FOUND_LOW_BIT] && !detectReport.done |=>
         state_r.foundLow;
   endproperty
   a_force_high: assert property (p_force_high) else $error("found flag not forced");

   property p_go;
      startReq |=> detectGo ##1 !detectGo;
   endproperty
   a_go: assert property (p_go) else $error("start pulse wrong");

   property p_reserved_zero;
      regReq.rd && detHit |=> regRvalid && regRdata[3:2] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   c_manual_run: cover property (startReq ##[1:20] detectReport.done);
   c_text_pair: cover property (regReq.wr && prodHit ##1 regReq.wr && prodHit);
   c_found: cover property (detectReport.done ##1 !state_r.foundLow);
endmodule

// *** testbench/detect_engine_model.sv ***
/*
 Behavioural detection engine at the far side of the charger detect register.
 Assumes the register group's clock, reset and manual start pulse.
*/
`timescale 1ns/1ps
module detect_engine_model
   import hub_regs_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic rst, // synchronous reset
   input wire logic detectGo, // manual start pulse
   input wire port_class_t runClass, // class reported at end of run
   input wire logic [3:0] runDelay, // run length in cycles
   output detect_report_t detectReport // end of run pulse
);
   logic [4:0] cnt;
   // ---------------------------------------------------------------
   // run counter, zero is idle; class wanders outside the done pulse
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      detectReport.done <= 1'b0;
      detectReport.cls <= port_class_t'(cnt[2:0]);
      if (rst) begin
         cnt <= 5'h00;
      end else if (detectGo) begin
         cnt <= {1'b0, runDelay} + 5'h01;
      end else if (cnt == 5'h01) begin
         cnt <= 5'h00;
         detectReport.done <= 1'b1;
         detectReport.cls <= runClass;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
   end
endmodule

// *** testbench/test_hub_string_and_charger_regs.sv ***
/*
 Self-checking bench of the hub string and charger register group.
 Assumes the byte access strobes of the design and the detection model.
*/
`timescale 1ns/1ps
module test_hub_string_and_charger_regs;
   import hub_regs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   reg_req_t regReq = '0;
   logic [7:0] regRdata;
   logic regRvalid;
   detect_report_t detectReport;
   logic extendedDetectOption = 1'b0;
   logic [2:0] detectTypeFilter = 3'h0;
   logic detectGo;
   logic [3:1] portChargeEnable;
   port_class_t runClass = CLS_NONE;
   logic [3:0] runDelay = 4'h4;
   logic goSeen;
   logic [7:0] rd;
   logic [7:0] expv;
   int miscompares = 0;
   int tests_run = 0;

   always #5 clk = ~clk;

   hub_string_and_charger_regs uut (.clk(clk), .rst(rst), .regReq(regReq),
      .regRdata(regRdata), .regRvalid(regRvalid), .detectReport(detectReport),
      .extendedDetectOption(extendedDetectOption), .detectTypeFilter(detectTypeFilter),
      .detectGo(detectGo), .portChargeEnable(portChargeEnable));
   detect_engine_model engine (.clk(clk), .rst(rst), .detectGo(detectGo),
      .runClass(runClass), .runDelay(runDelay), .detectReport(detectReport));

   // ---------------------------------------------------------------
   // access tasks; each starts and ends 1 ns after a rising edge
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // gap cycle after the strobe so no strobe is set twice in one step
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      regReq.wr = 1'b1;
      regReq.addr = a;
      regReq.wdata = d;
      @(posedge clk);
      #1 regReq.wr = 1'b0;
      goSeen = detectGo;
      @(posedge clk);
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      regReq.rd = 1'b1;
      regReq.addr = a;
      @(posedge clk);
      #1 regReq.rd = 1'b0;
      d = regRdata;
      check({7'h00, regRvalid}, 8'h01);
      @(posedge clk);
      #1;
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      check(d, e);
   endtask

   // expected result byte: class code, done, found-low
   function automatic logic [7:0] exp_det(input logic ext, input logic [2:0] f,
      input port_class_t c);
      logic [2:0] code;
      logic found;
      case (c)
         CLS_NONE: code = 3'h0;
         CLS_DCP: code = 3'h1;
         CLS_CDP: code = ext ? 3'h2 : 3'h1;
         CLS_SDP: code = 3'h3;
         default: code = 3'h7;
      endcase
      found = (c == CLS_DCP && !f[0]) || (c == CLS_CDP && !f[1]) || (c == CLS_SDP && !f[2]);
      return {code, 1'b1, 2'b00, ~found, 1'b0};
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog sized well above the expected run of about 260 cycles
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      rd_check(8'h54, 8'h00);
      rd_check(8'hCF, 8'h00);
      rd_check(8'hD0, 8'h00);
      rd_check(8'hE2, 8'h02);
      $display("test reset values done");
      // character pairs at 0x54, 0x72, 0x90 and 0xAE, low byte first, then unmapped neighbours
      for (int k = 0; k < 4; k++) begin
         expv = 8'h54 + 8'(k) * 8'h1E;
         wr_reg(expv, 8'hC5 + 8'(k));
         wr_reg(expv + 8'h01, 8'h30 + 8'(k));
         rd_check(expv, 8'hC5 + 8'(k));
         rd_check(expv + 8'h01, 8'h30 + 8'(k));
      end
      wr_reg(8'h53, 8'hFF);
      rd_check(8'h53, 8'h00);
      wr_reg(8'hD1, 8'hFF);
      rd_check(8'hD1, 8'h00);
      rd_check(8'h91, 8'h32);
      // write then read in the very next cycle; the read must see the new byte
      regReq.wr = 1'b1;
      regReq.addr = 8'hCE;
      regReq.wdata = 8'h6B;
      @(posedge clk);
      #1 regReq.wr = 1'b0;
      regReq.rd = 1'b1;
      @(posedge clk);
      #1 regReq.rd = 1'b0;
      check(regRdata, 8'h6B);
      check({7'h00, regRvalid}, 8'h01);
      @(posedge clk);
      #1;
      $display("test text areas done");
      wr_reg(8'hD0, 8'hFF);
      rd_check(8'hD0, 8'h0E);
      check({5'h00, portChargeEnable}, 8'h07);
      wr_reg(8'hD0, 8'h05);
      check({5'h00, portChargeEnable}, 8'h02);
      $display("test charge enables done");
      for (int i = 0; i < 10; i++) begin
         extendedDetectOption = (i >= 5);
         detectTypeFilter = 3'(i * 3);
         runClass = port_class_t'(i % 5);
         runDelay = 4'(4 + i % 4);
         expv = exp_det(extendedDetectOption, detectTypeFilter, runClass);
         wr_reg(8'hE2, 8'h01); // start only issued while no run is going
         check({7'h00, goSeen}, 8'h01);
         check({7'h00, detectGo}, 8'h00);
         rd_reg(8'hE2, rd);
         check(rd & 8'h11, 8'h01);
         wr_reg(8'hE2, 8'hFF);
         check({7'h00, goSeen}, 8'h00);
         for (int w = 0; w < 40 && detectReport.done !== 1'b1; w++) begin
            @(posedge clk);
            #1;
         end
         @(posedge clk);
         #1;
         rd_check(8'hE2, expv);
         wr_reg(8'hE2, 8'hFC);
         rd_check(8'hE2, expv);
         wr_reg(8'hE2, 8'h02);
         rd_check(8'hE2, expv | 8'h02);
      end
      $display("test charger detection done");
      end_of_test();
   end
endmodule
